// >>> rtl/eeprom_indirect_access_ctrl.sv
// Indirect EEPROM access controller: registers, command sequencing and load
//
// Functional notes
// - Block write fills every address with buffer
// - Batch write copies function registers to EEPROM
// - Single write programs buffer at indexed address
// - Batch read loads EEPROM image into registers
// - Single read fills buffer; bit clears when done
// - Enabled flag read-only; disable bit write-only
// - Each batch pulse writes two bytes, address +2
// - Batch write ends after 64 bytes
// - Writing zero to command register aborts pending or armed operation; a running read or load completes
// - Pulse rise starts, fall ends write or erase
// - Block erase plus pulse erases whole array
// - Power-on load starts ten cycles after reset
// - Power-on load lasts 512 clock cycles
// - Internal reset held 150 us after power-up
// - Simultaneous commands: only highest priority kept
// - Busy bit reads one while operation runs
// - Eight-bit index, sixteen-bit buffer in two bytes
`timescale 1ns/1ps
`include "eeprom_regs.svh"
module eeprom_indirect_access_ctrl #(
    parameter int RST_HOLD_CYCLES = `RST_HOLD_US * 1000 / `CLK_PERIOD_NS
) (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Register port
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    input  wire logic [7:0]  reg_addr_i,
    input  wire logic [7:0]  reg_wdata_i,
    output logic      [7:0]  reg_rdata_o,
    // Internal function registers
    output logic             func_wr_o,
    output logic      [5:0]  func_addr_o,
    output logic      [15:0] func_wdata_o,
    input  wire logic [15:0] func_rdata_i,
    // Status
    output logic             int_rst_o
);
    // ------------------------------------------------------------------
    // Submodules
    // ------------------------------------------------------------------
    nvm_if nvm ();
    logic  por_hold;
    logic  load_start;
    logic  rst_all;

    nvm_array #(.DEPTH(256)) u_array (
        .clk_i (clk_i),
        .port  (nvm.mem)
    );

    por_loader #(.RST_HOLD_CYCLES(RST_HOLD_CYCLES)) u_por (
        .clk_i        (clk_i),
        .rst_i        (rst_i),
        .hold_o       (por_hold),
        .load_start_o (load_start)
    );

    assign rst_all   = rst_i || por_hold;
    assign int_rst_o = por_hold;

    // Keeps only the lowest set bit, which is the highest priority command
    function automatic logic [6:0] pick_cmd(input logic [6:0] v);
        pick_cmd = v & (~v + 7'h01);
    endfunction : pick_cmd

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    eeprom_pkg::ctrl_state_e state_r, state_nxt;
    logic [7:0]        index_r, index_nxt;
    eeprom_pkg::word_t buffer_r, buffer_nxt;
    logic [6:0]        cmd_r, cmd_nxt;
    logic              enabled_r, enabled_nxt;
    logic [3:0]        gate_keep_r, gate_keep_nxt;
    logic [7:0]        timing_r, timing_nxt;
    logic [8:0]        ld_cnt_r, ld_cnt_nxt;
    logic [5:0]        bw_ptr_r, bw_ptr_nxt;
    logic [7:0]        rdata_r, rdata_nxt;
    logic              fwr_r, fwr_nxt;
    logic [5:0]        faddr_r, faddr_nxt;
    eeprom_pkg::word_t fdata_r, fdata_nxt;

    logic wr_cmd, wr_gate, wr_timing, pulse_rise, pulse_fall, busy, commit;

    assign wr_cmd     = reg_wr_i && reg_addr_i == `ADDR_CMD_STATUS;
    assign wr_gate    = reg_wr_i && reg_addr_i == `ADDR_ACCESS_GATE;
    assign wr_timing  = reg_wr_i && reg_addr_i == `ADDR_PROG_TIMING;
    assign pulse_rise = wr_timing && reg_wdata_i[`BIT_PROG_PULSE] && !timing_r[`BIT_PROG_PULSE];
    assign pulse_fall = wr_timing && !reg_wdata_i[`BIT_PROG_PULSE] && timing_r[`BIT_PROG_PULSE];
    assign busy       = state_r != eeprom_pkg::ST_IDLE;
    assign commit     = state_r == eeprom_pkg::ST_ARMED && pulse_fall && cmd_r != 7'h00;

    assign reg_rdata_o  = rdata_r;
    assign func_wr_o    = fwr_r;
    assign func_addr_o  = faddr_r;
    assign func_wdata_o = fdata_r;

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        state_nxt     = state_r;
        index_nxt     = index_r;
        buffer_nxt    = buffer_r;
        cmd_nxt       = cmd_r;
        enabled_nxt   = enabled_r;
        gate_keep_nxt = gate_keep_r;
        timing_nxt    = timing_r;
        ld_cnt_nxt    = ld_cnt_r;
        bw_ptr_nxt    = bw_ptr_r;
        fwr_nxt       = 1'b0;
        faddr_nxt     = faddr_r;
        fdata_nxt     = fdata_r;
        nvm.rd        = 1'b0;
        nvm.wr        = 1'b0;
        nvm.fill      = 1'b0;
        nvm.addr      = index_r;
        nvm.wdata     = buffer_r;

        // Register writes
        if (reg_wr_i && reg_addr_i == `ADDR_WORD_INDEX) begin
            index_nxt = reg_wdata_i;
        end
        if (reg_wr_i && reg_addr_i == `ADDR_BUFFER_LOW) begin
            buffer_nxt[7:0] = reg_wdata_i;
        end
        if (reg_wr_i && reg_addr_i == `ADDR_BUFFER_HIGH) begin
            buffer_nxt[15:8] = reg_wdata_i;
        end
        if (wr_gate) begin
            gate_keep_nxt = reg_wdata_i[5:2];
            if (reg_wdata_i[`BIT_DISABLE]) begin
                enabled_nxt = 1'b0;
            end else if (reg_wdata_i[`BIT_ENABLE]) begin
                enabled_nxt = 1'b1;
            end
        end
        if (wr_timing) begin
            timing_nxt = reg_wdata_i;
        end
        if (wr_cmd && reg_wdata_i[6:0] == 7'h00) begin
            cmd_nxt    = 7'h00;
            bw_ptr_nxt = 6'h00;
            if (state_r == eeprom_pkg::ST_ARMED) begin
                state_nxt = eeprom_pkg::ST_IDLE;
            end
        end else if (wr_cmd && enabled_r && !busy && cmd_r == 7'h00) begin
            cmd_nxt    = pick_cmd(reg_wdata_i[6:0]);
            bw_ptr_nxt = 6'h00;
        end

        // Sequencing
        case (state_r)
            eeprom_pkg::ST_IDLE: begin
                if (load_start) begin
                    ld_cnt_nxt = 9'h000;
                    state_nxt  = eeprom_pkg::ST_LOAD;
                end else if (enabled_r && cmd_r[`BIT_SINGLE_READ]) begin
                    nvm.rd    = 1'b1;
                    state_nxt = eeprom_pkg::ST_READ;
                end else if (enabled_r && cmd_r[`BIT_BATCH_READ]) begin
                    ld_cnt_nxt = 9'h000;
                    state_nxt  = eeprom_pkg::ST_LOAD;
                end else if (enabled_r && pulse_rise && cmd_r[6:2] != 5'h00) begin
                    state_nxt = eeprom_pkg::ST_ARMED;
                    faddr_nxt = bw_ptr_r;
                end
            end
            eeprom_pkg::ST_READ: begin
                buffer_nxt = nvm.rdata;
                cmd_nxt    = 7'h00;
                state_nxt  = eeprom_pkg::ST_IDLE;
            end
            eeprom_pkg::ST_LOAD: begin
                // One word every sixteen cycles: 32 words in 512 cycles
                nvm.addr   = {3'h0, ld_cnt_r[8:4]};
                nvm.rd     = ld_cnt_r[3:0] == 4'h0;
                ld_cnt_nxt = ld_cnt_r + 9'h001;
                if (ld_cnt_r[3:0] == 4'h1) begin
                    fwr_nxt   = 1'b1;
                    faddr_nxt = {ld_cnt_r[8:4], 1'b0};
                    fdata_nxt = nvm.rdata;
                end
                if (ld_cnt_r == 9'(`TEPR_CYCLES - 1)) begin
                    cmd_nxt   = 7'h00;
                    state_nxt = eeprom_pkg::ST_IDLE;
                end
            end
            eeprom_pkg::ST_ARMED: begin
                if (commit) begin
                    state_nxt = eeprom_pkg::ST_IDLE;
                    cmd_nxt   = 7'h00;
                    if (cmd_r[`BIT_SINGLE_WRITE]) begin
                        nvm.wr = 1'b1;
                    end else if (cmd_r[`BIT_BATCH_WRITE]) begin
                        // Unbacked addresses take whatever the function side returns
                        nvm.wr     = 1'b1;
                        nvm.addr   = {3'h0, bw_ptr_r[5:1]};
                        nvm.wdata  = func_rdata_i;
                        bw_ptr_nxt = bw_ptr_r + 6'h02;
                        if (bw_ptr_r != `BATCH_LAST_PTR) begin
                            cmd_nxt = cmd_r;
                        end
                    end else if (cmd_r[`BIT_BLOCK_WRITE]) begin
                        nvm.fill = 1'b1;
                    end else if (cmd_r[`BIT_ADDR_ERASE]) begin
                        nvm.wr    = 1'b1;
                        nvm.wdata = `ERASED_WORD;
                    end else begin
                        nvm.fill  = 1'b1;
                        nvm.wdata = `ERASED_WORD;
                    end
                end else if (pulse_fall) begin
                    state_nxt = eeprom_pkg::ST_IDLE;
                end
            end
            default: begin
                state_nxt = eeprom_pkg::ST_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------------
    always_comb begin
        rdata_nxt = rdata_r;
        if (reg_rd_i) begin
            case (reg_addr_i)
                `ADDR_WORD_INDEX:  rdata_nxt = index_r;
                `ADDR_BUFFER_LOW:  rdata_nxt = buffer_r[7:0];
                `ADDR_BUFFER_HIGH: rdata_nxt = buffer_r[15:8];
                `ADDR_CMD_STATUS:  rdata_nxt = {busy, cmd_r};
                `ADDR_ACCESS_GATE: rdata_nxt = {enabled_r, 1'b0, gate_keep_r[3:0], 2'b00};
                `ADDR_PROG_TIMING: rdata_nxt = timing_r;
                default:           rdata_nxt = `RESET_BYTE;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_all) begin
            state_r     <= eeprom_pkg::ST_IDLE;
            index_r     <= `RESET_BYTE;
            buffer_r    <= 16'h0000;
            cmd_r       <= 7'h00;
            enabled_r   <= 1'b0;
            gate_keep_r <= 4'h0;
            timing_r    <= `RESET_BYTE;
            ld_cnt_r    <= 9'h000;
            bw_ptr_r    <= 6'h00;
            rdata_r     <= `RESET_BYTE;
            fwr_r       <= 1'b0;
            faddr_r     <= 6'h00;
            fdata_r     <= 16'h0000;
        end else begin
            state_r     <= state_nxt;
            index_r     <= index_nxt;
            buffer_r    <= buffer_nxt;
            cmd_r       <= cmd_nxt;
            enabled_r   <= enabled_nxt;
            gate_keep_r <= gate_keep_nxt;
            timing_r    <= timing_nxt;
            ld_cnt_r    <= ld_cnt_nxt;
            bw_ptr_r    <= bw_ptr_nxt;
            rdata_r     <= rdata_nxt;
            fwr_r       <= fwr_nxt;
            faddr_r     <= faddr_nxt;
            fdata_r     <= fdata_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_all);

    sequence s_read_issue;
        state_r == eeprom_pkg::ST_IDLE && nvm.rd && !load_start;
    endsequence
    sequence s_read_finish;
        cmd_r[`BIT_SINGLE_READ] ##1 !cmd_r[`BIT_SINGLE_READ] && !busy;
    endsequence

    chk_read_seq: assert property (s_read_issue |=> s_read_finish)
        else $error("single read did not hold then clear its command bit");
    chk_prio_onehot: assert property ($onehot0(cmd_r))
        else $error("more than one command bit is pending");
    chk_busy_read: assert property (reg_rd_i && reg_addr_i == `ADDR_CMD_STATUS
        |=> reg_rdata_o[`BIT_BUSY] == $past(busy))
        else $error("busy bit does not reflect controller activity");
    chk_load_len: assert property ($rose(state_r == eeprom_pkg::ST_LOAD)
        |-> (state_r == eeprom_pkg::ST_LOAD && ld_cnt_r == 9'h000))
        else $error("load did not start from count zero");
    chk_load_end: assert property (state_r == eeprom_pkg::ST_LOAD
        && ld_cnt_r == 9'(`TEPR_CYCLES - 1) |=> state_r == eeprom_pkg::ST_IDLE)
        else $error("load did not end after 512 cycles");
    chk_gate_ignore: assert property (!enabled_r && wr_cmd
        && reg_wdata_i[6:0] != 7'h00 |=> $stable(cmd_r))
        else $error("command accepted while access disabled");
    chk_batch_step: assert property (commit && cmd_r[`BIT_BATCH_WRITE]
        |=> bw_ptr_r == $past(bw_ptr_r) + 6'h02)
        else $error("batch pointer did not advance by two");
    chk_batch_end: assert property (commit && cmd_r[`BIT_BATCH_WRITE]
        && bw_ptr_r == `BATCH_LAST_PTR |=> cmd_r == 7'h00)
        else $error("batch write did not finish after 64 bytes");
    chk_abort_clear: assert property (wr_cmd && reg_wdata_i[6:0] == 7'h00
        |=> cmd_r == 7'h00 && state_r != eeprom_pkg::ST_ARMED)
        else $error("zero write did not abort the operation");
    chk_arm_start: assert property (state_r == eeprom_pkg::ST_IDLE && enabled_r
        && !load_start && cmd_r[6:2] != 5'h00 && pulse_rise
        |=> state_r == eeprom_pkg::ST_ARMED)
        else $error("program pulse rise did not start the operation");
endmodule : eeprom_indirect_access_ctrl

// >>> common/eeprom_regs.svh
// Register offsets, field positions and timing counts of the EEPROM access block
`ifndef EEPROM_REGS_SVH
`define EEPROM_REGS_SVH
`define ADDR_WORD_INDEX     8'h40
`define ADDR_BUFFER_LOW     8'h42
`define ADDR_BUFFER_HIGH    8'h43
`define ADDR_CMD_STATUS     8'h44
`define ADDR_ACCESS_GATE    8'h45
`define ADDR_PROG_TIMING    8'h46
`define RESET_BYTE          8'h00
`define BIT_BUSY            7
`define BIT_SINGLE_READ     0
`define BIT_BATCH_READ      1
`define BIT_SINGLE_WRITE    2
`define BIT_BATCH_WRITE     3
`define BIT_BLOCK_WRITE     4
`define BIT_ADDR_ERASE      5
`define BIT_BLOCK_ERASE     6
`define BIT_ENABLE          0
`define BIT_DISABLE         1
`define BIT_ENABLED_FLAG    7
`define BIT_PROG_PULSE      0
`define ERASED_WORD         16'hFFFF
`define BATCH_LAST_PTR      6'h3E
`define CLK_PERIOD_NS       5
`define RST_HOLD_US         150
`define TWAIT_CYCLES        10
`define TEPR_CYCLES         512
`endif

// >>> common/eeprom_pkg.sv
// Types shared by the EEPROM access block
package eeprom_pkg;
    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0001,
        ST_READ  = 4'b0010,
        ST_LOAD  = 4'b0100,
        ST_ARMED = 4'b1000
    } ctrl_state_e;
    typedef logic [15:0] word_t;
endpackage : eeprom_pkg

// >>> common/nvm_if.sv
// Access channel between the controller and the storage array
`timescale 1ns/1ps
interface nvm_if;
    logic                rd;
    logic                wr;
    logic                fill;
    logic [7:0]          addr;
    eeprom_pkg::word_t   wdata;
    eeprom_pkg::word_t   rdata;
    modport ctrl (output rd, output wr, output fill, output addr, output wdata, input rdata);
    modport mem  (input rd, input wr, input fill, input addr, input wdata, output rdata);
endinterface : nvm_if

// >>> rtl/nvm_array.sv
// Word-wide EEPROM storage array with single and whole-array programming
`timescale 1ns/1ps
module nvm_array #(
    parameter int DEPTH = 256
) (
    input  wire logic clk_i,
    nvm_if.mem        port
);
    eeprom_pkg::word_t mem_r [DEPTH];
    eeprom_pkg::word_t rdata_r;

    assign port.rdata = rdata_r;

    // Whole-array fill takes one edge; real cells would take the pulse time
    always_ff @(posedge clk_i) begin
        if (port.rd) begin
            rdata_r <= mem_r[port.addr];
        end
        if (port.fill) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_r[i] <= port.wdata;
            end
        end else if (port.wr) begin
            mem_r[port.addr] <= port.wdata;
        end
    end
endmodule : nvm_array

// >>> rtl/por_loader.sv
// Internal reset stretch and power-on load trigger
`timescale 1ns/1ps
`include "eeprom_regs.svh"
module por_loader #(
    parameter int RST_HOLD_CYCLES = `RST_HOLD_US * 1000 / `CLK_PERIOD_NS
) (
    input  wire logic clk_i,
    input  wire logic rst_i,
    output logic      hold_o,
    output logic      load_start_o
);
    localparam int CW = $clog2(RST_HOLD_CYCLES + 1);
    logic [CW-1:0] hold_cnt_r, hold_cnt_nxt;
    logic [3:0]    wait_cnt_r, wait_cnt_nxt;

    assign hold_o       = hold_cnt_r != CW'(RST_HOLD_CYCLES);
    assign load_start_o = !hold_o && (wait_cnt_r == 4'(`TWAIT_CYCLES - 1));

    always_comb begin
        hold_cnt_nxt = hold_cnt_r;
        wait_cnt_nxt = wait_cnt_r;
        if (hold_o) begin
            hold_cnt_nxt = hold_cnt_r + CW'(1);
        end else if (wait_cnt_r != 4'(`TWAIT_CYCLES)) begin
            wait_cnt_nxt = wait_cnt_r + 4'h1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            hold_cnt_r <= '0;
            wait_cnt_r <= 4'h0;
        end else begin
            hold_cnt_r <= hold_cnt_nxt;
            wait_cnt_r <= wait_cnt_nxt;
        end
    end

    chk_load_wait: assert property (@(posedge clk_i) disable iff (rst_i)
        $fell(hold_o) |-> ##9 load_start_o)
        else $error("power-on load did not start ten cycles after reset release");
endmodule : por_loader

// >>> verif/eeprom_indirect_access_ctrl_test.sv
// Self-checking bench for the EEPROM indirect access controller
`timescale 1ns/1ps
`include "eeprom_regs.svh"
module eeprom_indirect_access_ctrl_test;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic        clk_i;
    logic        rst_i;
    logic        reg_wr_i;
    logic        reg_rd_i;
    logic [7:0]  reg_addr_i;
    logic [7:0]  reg_wdata_i;
    logic [7:0]  reg_rdata_o;
    logic        func_wr_o;
    logic [5:0]  func_addr_o;
    logic [15:0] func_wdata_o;
    logic [15:0] func_rdata_i;
    logic        int_rst_o;
    logic        check_func;
    logic [7:0]  b;
    int          mismatches;
    int          n_compared;
    int          n_pulse;

    eeprom_indirect_access_ctrl #(.RST_HOLD_CYCLES(20)) dut_u (
        .clk_i(clk_i), .rst_i(rst_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
        .func_wr_o(func_wr_o), .func_addr_o(func_addr_o), .func_wdata_o(func_wdata_o),
        .func_rdata_i(func_rdata_i), .int_rst_o(int_rst_o));

    // Address-dependent pattern so a misplaced word shows up
    function automatic logic [15:0] pat(input logic [5:0] a);
        return {2'b10, a, 8'h3c};
    endfunction : pat
    assign func_rdata_i = pat(func_addr_o);

    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end

    // ------------------------------------------------------------
    // Checking and access tasks
    // ------------------------------------------------------------
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_byte
    task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_word
    task automatic report_and_stop;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : report_and_stop
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        reg_wr_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge clk_i);
        reg_wr_i <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_i);
        reg_rd_i <= 1'b1;
        reg_addr_i <= a;
        @(posedge clk_i);
        reg_rd_i <= 1'b0;
        @(negedge clk_i);
        d = reg_rdata_o;
    endtask : rd
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        rd(a, d);
        chk_byte(d, exp);
    endtask : rd_chk
    // Polls the command register; a stuck command counts as a failure
    task automatic wait_idle;
        logic [7:0] d;
        for (int i = 0; i < 400; i++) begin
            rd(`ADDR_CMD_STATUS, d);
            if (d === 8'h00) return;
        end
        mismatches++;
        report_and_stop();
    endtask : wait_idle
    task automatic set_buf(input logic [15:0] w);
        wr(`ADDR_BUFFER_LOW, w[7:0]);
        wr(`ADDR_BUFFER_HIGH, w[15:8]);
    endtask : set_buf
    task automatic rd_word(input logic [7:0] idx, input logic [15:0] exp);
        logic [7:0] lo;
        logic [7:0] hi;
        wr(`ADDR_WORD_INDEX, idx);
        wr(`ADDR_CMD_STATUS, 8'h01);
        wait_idle();
        rd(`ADDR_BUFFER_LOW, lo);
        rd(`ADDR_BUFFER_HIGH, hi);
        chk_word({hi, lo}, exp);
    endtask : rd_word
    task automatic prog(input logic [7:0] cmd);
        wr(`ADDR_CMD_STATUS, cmd);
        wr(`ADDR_PROG_TIMING, 8'h01);
        repeat (8) @(posedge clk_i);
        wr(`ADDR_PROG_TIMING, 8'h00);
        wait_idle();
    endtask : prog

    always @(negedge clk_i) begin
        if (func_wr_o === 1'b1) begin
            n_pulse++;
            if (check_func) chk_word(func_wdata_o, pat(func_addr_o));
        end
    end

    initial begin
        repeat (100000) @(posedge clk_i);
        mismatches++;
        report_and_stop();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        {rst_i, reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i} <= {1'b1, 18'h0_0000};
        {mismatches, n_compared, n_pulse, check_func} = '0;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        chk_byte({7'h00, int_rst_o}, 8'h01);
        for (int i = 0; i < 200 && int_rst_o !== 1'b0; i++) @(posedge clk_i);
        chk_byte({7'h00, int_rst_o}, 8'h00);
        repeat (600) @(posedge clk_i);
        chk_byte(n_pulse[7:0], 8'h20);
        for (int a = 8'h40; a <= 8'h46; a++) rd_chk(a[7:0], 8'h00);
        wr(`ADDR_CMD_STATUS, 8'h01);
        rd_chk(`ADDR_CMD_STATUS, 8'h00);
        wr(`ADDR_ACCESS_GATE, 8'h01);
        rd_chk(`ADDR_ACCESS_GATE, 8'h80);
        wr(`ADDR_WORD_INDEX, 8'h12);
        rd_chk(`ADDR_WORD_INDEX, 8'h12);
        set_buf(16'hbeef);
        wr(`ADDR_CMD_STATUS, 8'h04);
        wr(`ADDR_PROG_TIMING, 8'h01);
        rd_chk(`ADDR_CMD_STATUS, 8'h84);
        wr(`ADDR_PROG_TIMING, 8'h00);
        wait_idle();
        set_buf(16'h0000);
        rd_word(8'h12, 16'hbeef);
        prog(8'h20);
        rd_word(8'h12, 16'hffff);
        set_buf(16'ha55a);
        prog(8'h10);
        rd_word(8'h00, 16'ha55a);
        rd_word(8'hff, 16'ha55a);
        prog(8'h40);
        rd_word(8'h80, 16'hffff);
        set_buf(16'h1234);
        wr(`ADDR_CMD_STATUS, 8'h05);
        wait_idle();
        rd(`ADDR_BUFFER_HIGH, b);
        chk_byte(b, 8'hff);
        wr(`ADDR_CMD_STATUS, 8'h08);
        for (int i = 0; i < 32; i++) begin
            rd(`ADDR_CMD_STATUS, b);
            chk_byte({1'b0, b[6:0]}, 8'h08);
            wr(`ADDR_PROG_TIMING, 8'h01);
            wr(`ADDR_PROG_TIMING, 8'h00);
        end
        rd_chk(`ADDR_CMD_STATUS, 8'h00);
        n_pulse = 0;
        check_func = 1'b1;
        wr(`ADDR_CMD_STATUS, 8'h02);
        wait_idle();
        check_func = 1'b0;
        chk_byte(n_pulse[7:0], 8'h20);
        wr(`ADDR_CMD_STATUS, 8'h08);
        wr(`ADDR_PROG_TIMING, 8'h01);
        wr(`ADDR_PROG_TIMING, 8'h00);
        wr(`ADDR_PROG_TIMING, 8'h01);
        wr(`ADDR_CMD_STATUS, 8'h00);
        wr(`ADDR_PROG_TIMING, 8'h00);
        rd_chk(`ADDR_CMD_STATUS, 8'h00);
        wr(`ADDR_PROG_TIMING, 8'h60);
        rd_chk(`ADDR_PROG_TIMING, 8'h60);
        wr(`ADDR_PROG_TIMING, 8'h00);
        wr(`ADDR_ACCESS_GATE, 8'h02);
        rd_chk(`ADDR_ACCESS_GATE, 8'h00);
        wr(`ADDR_CMD_STATUS, 8'h01);
        rd_chk(`ADDR_CMD_STATUS, 8'h00);
        report_and_stop();
    end
endmodule : eeprom_indirect_access_ctrl_test
